// >>> ackp_pkg.sv
// Purpose: Shared constants for the application control block port.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Lane slice layouts and block type field codes live here.
package ackp_pkg;
  localparam int          LANES        = 1;
  localparam int          SLICE_W      = 64;
  localparam int          BUS_W        = SLICE_W * LANES;
  localparam int          BLK_NO_W     = 4;
  localparam int          PAYLOAD_W    = 56;
  localparam int          BTF_W        = 8;
  // Default ordering field positions (MSB-first numbering 0..63 maps to
  // vector bits 63..0): zeros 0:3, number 4:7, payload 8:63
  localparam int          DEF_ZERO_HI  = 63;
  localparam int          DEF_NO_HI    = 59;
  localparam int          DEF_NO_LO    = 56;
  localparam int          DEF_PL_HI    = 55;
  // Little-endian positions: payload 63:8, zeros 7:4, number 3:0
  localparam int          LE_PL_LO     = 8;
  localparam int          LE_NO_HI     = 3;
  localparam int          LE_ZERO_HI   = 7;
  localparam int          LE_ZERO_LO   = 4;
  localparam int          NUM_BLOCKS   = 9;
  localparam logic [3:0]  MAX_BLK_NO   = 4'h8;
  localparam logic [7:0]  BTF_0        = 8'hd2;
  localparam logic [7:0]  BTF_1        = 8'h99;
  localparam logic [7:0]  BTF_2        = 8'h55;
  localparam logic [7:0]  BTF_3        = 8'hb4;
  localparam logic [7:0]  BTF_4        = 8'hcc;
  localparam logic [7:0]  BTF_5        = 8'h66;
  localparam logic [7:0]  BTF_6        = 8'h33;
  localparam logic [7:0]  BTF_7        = 8'h4b;
  localparam logic [7:0]  BTF_8        = 8'h87;
  localparam logic [7:0]  BTF_NONE     = 8'h00;

  typedef enum logic [1:0] {
    ACKP_SRC_IDLE,
    ACKP_SRC_HIGH,
    ACKP_SRC_CTRL,
    ACKP_SRC_DATA
  } ackp_src_e;
endpackage : ackp_pkg

// >>> ackp_btf_enc.sv
// Purpose: Map a block number to its block type field code.
// Assumes: Numbers above eight are flagged as undefined.
// Notes:   Pure combinational lookup.
`timescale 1ns/1ps
module ackp_btf_enc
  import ackp_pkg::*;
(
  input  wire logic [3:0] i_blk_no,
  output logic      [7:0] o_btf,
  output logic            o_ok
);
  always_comb begin
    o_ok = 1'b1;
    case (i_blk_no)
      4'h0: o_btf = BTF_0;
      4'h1: o_btf = BTF_1;
      4'h2: o_btf = BTF_2;
      4'h3: o_btf = BTF_3;
      4'h4: o_btf = BTF_4;
      4'h5: o_btf = BTF_5;
      4'h6: o_btf = BTF_6;
      4'h7: o_btf = BTF_7;
      4'h8: o_btf = BTF_8;
      default: begin
        o_btf = BTF_NONE;
        o_ok  = 1'b0;
      end
    endcase
  end
endmodule : ackp_btf_enc

// >>> ackp_btf_dec.sv
// Purpose: Map a received block type field back to its block number.
// Assumes: Only the nine control codes count as a match.
// Notes:   Pure combinational lookup.
`timescale 1ns/1ps
module ackp_btf_dec
  import ackp_pkg::*;
(
  input  wire logic [7:0] i_btf,
  output logic      [3:0] o_blk_no,
  output logic            o_hit
);
  always_comb begin
    o_hit = 1'b1;
    case (i_btf)
      BTF_0:   o_blk_no = 4'h0;
      BTF_1:   o_blk_no = 4'h1;
      BTF_2:   o_blk_no = 4'h2;
      BTF_3:   o_blk_no = 4'h3;
      BTF_4:   o_blk_no = 4'h4;
      BTF_5:   o_blk_no = 4'h5;
      BTF_6:   o_blk_no = 4'h6;
      BTF_7:   o_blk_no = 4'h7;
      BTF_8:   o_blk_no = 4'h8;
      default: begin
        o_blk_no = 4'h0;
        o_hit    = 1'b0;
      end
    endcase
  end
endmodule : ackp_btf_dec

// >>> ackp_port.sv
// Purpose: Transmit and receive port for application control blocks.
// Assumes: Single lane, i_ref_clk at 20 MHz, synchronous reset.
// Notes:   Link side is a registered block stream with a type field.
// Overview of operation
// - Control blocks rank below user flow control, above user data.
// - Payload passes through untouched; never interpreted.
// - Default slice: zeros bits 0-3, number 4-7, payload 8-63.
// - Little-endian slice: payload 63:8, zeros 7:4, number 3:0.
// - Ready is high whenever the port can take a block.
// - Ready drops while higher-priority operations are sent.
// - Every block offered while ready is high is sent, none dropped.
// - Each block goes out as eight bytes with mapped type field.
// - Only seven payload bytes carry content; one byte is header.
// - Streaming and framed link modes treat blocks alike.
// - Received type field maps back to number in chosen ordering.
// - Received blocks appear 64-bit aligned in transmit layout.
// - Receive valid pulses one cycle per block with a known type field; data then holds.
`timescale 1ns/1ps
module ackp_port
  import ackp_pkg::*;
(
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst_b,
  input  wire logic               i_little_endian,
  input  wire logic               i_framed_mode,
  input  wire logic               i_clock_compensation_req,
  input  wire logic               i_channel_bonding_req,
  input  wire logic               i_native_flow_control_req,
  input  wire logic               i_user_flow_control_req,
  input  wire logic               i_user_data_valid,
  input  wire logic [BUS_W-1:0]   i_ctl_tx_data,
  input  wire logic               i_ctl_tx_valid,
  output logic                    o_ctl_tx_ready,
  output logic                    o_user_data_ready,
  output logic                    o_link_tx_valid,
  output logic                    o_link_tx_is_ctl,
  output logic [BTF_W-1:0]        o_link_tx_btf,
  output logic [PAYLOAD_W-1:0]    o_link_tx_payload,
  output logic                    o_ctl_tx_bad_no,
  input  wire logic               i_link_rx_valid,
  input  wire logic [BTF_W-1:0]   i_link_rx_btf,
  input  wire logic [PAYLOAD_W-1:0] i_link_rx_payload,
  output logic [BUS_W-1:0]        o_ctl_rx_data,
  output logic                    o_ctl_rx_valid
);
  logic                 high_busy;
  logic                 ctl_take;
  logic [3:0]           tx_no;
  logic [PAYLOAD_W-1:0] tx_pl;
  logic [7:0]           tx_btf;
  logic                 tx_ok;
  logic [3:0]           rx_no;
  logic                 rx_hit;
  logic [SLICE_W-1:0]   rx_slice;

  logic                 link_valid_ff, nxt_link_valid;
  logic                 link_ctl_ff,   nxt_link_ctl;
  logic [BTF_W-1:0]     link_btf_ff,   nxt_link_btf;
  logic [PAYLOAD_W-1:0] link_pl_ff,    nxt_link_pl;
  logic                 bad_no_ff,     nxt_bad_no;
  logic [BUS_W-1:0]     rx_data_ff,    nxt_rx_data;
  logic                 rx_valid_ff,   nxt_rx_valid;

  // Mode select is independent of streaming/framed setting
  logic                 unused_framed;
  assign unused_framed = i_framed_mode;

  // Higher-priority senders hold the link this cycle
  assign high_busy = i_clock_compensation_req | i_channel_bonding_req
                   | i_native_flow_control_req
                   | i_user_flow_control_req;
  assign o_ctl_tx_ready    = ~high_busy;
  assign ctl_take          = i_ctl_tx_valid & o_ctl_tx_ready;
  // User data only wins when no control block is offered
  assign o_user_data_ready = ~high_busy & ~i_ctl_tx_valid;

  // Lane slice unpacking (lane 0; fields identical in every lane)
  always_comb begin
    if (i_little_endian) begin
      tx_no = i_ctl_tx_data[LE_NO_HI:0];
      tx_pl = i_ctl_tx_data[SLICE_W-1:LE_PL_LO];
    end else begin
      tx_no = i_ctl_tx_data[DEF_NO_HI:DEF_NO_LO];
      tx_pl = i_ctl_tx_data[DEF_PL_HI:0];
    end
  end

  ackp_btf_enc u_enc (
    .i_blk_no (tx_no),
    .o_btf    (tx_btf),
    .o_ok     (tx_ok)
  );

  ackp_btf_dec u_dec (
    .i_btf    (i_link_rx_btf),
    .o_blk_no (rx_no),
    .o_hit    (rx_hit)
  );

  // Transmit side: accepted block becomes one eight-byte link block
  always_comb begin
    nxt_link_valid = ctl_take;
    nxt_link_ctl   = ctl_take;
    nxt_link_btf   = ctl_take ? tx_btf : BTF_NONE;
    nxt_link_pl    = ctl_take ? tx_pl : '0;
    // Undefined numbers still go out, flagged, rather than vanish
    nxt_bad_no     = ctl_take & ~tx_ok;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      link_valid_ff <= 1'b0;
      link_ctl_ff   <= 1'b0;
      link_btf_ff   <= BTF_NONE;
      link_pl_ff    <= '0;
      bad_no_ff     <= 1'b0;
    end else begin
      link_valid_ff <= nxt_link_valid;
      link_ctl_ff   <= nxt_link_ctl;
      link_btf_ff   <= nxt_link_btf;
      link_pl_ff    <= nxt_link_pl;
      bad_no_ff     <= nxt_bad_no;
    end
  end

  assign o_link_tx_valid   = link_valid_ff;
  assign o_link_tx_is_ctl  = link_ctl_ff;
  assign o_link_tx_btf     = link_btf_ff;
  assign o_link_tx_payload = link_pl_ff;
  assign o_ctl_tx_bad_no   = bad_no_ff;

  // Receive side: rebuild the slice in the configured ordering
  always_comb begin
    rx_slice = '0;
    if (i_little_endian) begin
      rx_slice[SLICE_W-1:LE_PL_LO] = i_link_rx_payload;
      rx_slice[LE_NO_HI:0]         = rx_no;
    end else begin
      rx_slice[DEF_NO_HI:DEF_NO_LO] = rx_no;
      rx_slice[DEF_PL_HI:0]         = i_link_rx_payload;
    end
  end

  always_comb begin
    nxt_rx_valid = i_link_rx_valid & rx_hit;
    nxt_rx_data  = rx_data_ff;
    if (nxt_rx_valid) begin
      nxt_rx_data = {LANES{rx_slice}};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      rx_data_ff  <= '0;
      rx_valid_ff <= 1'b0;
    end else begin
      rx_data_ff  <= nxt_rx_data;
      rx_valid_ff <= nxt_rx_valid;
    end
  end

  assign o_ctl_rx_data  = rx_data_ff;
  assign o_ctl_rx_valid = rx_valid_ff;

  // Checks
  property p_ready_blocked;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_clock_compensation_req || i_channel_bonding_req
        || i_native_flow_control_req || i_user_flow_control_req)
        |-> !o_ctl_tx_ready;
  endproperty
  a_ready_blocked: assert property (p_ready_blocked)
    else $error("ctl ready high during priority op");

  property p_take_sent;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_ctl_tx_valid && o_ctl_tx_ready) |=>
        (o_link_tx_valid && o_link_tx_is_ctl);
  endproperty
  a_take_sent: assert property (p_take_sent)
    else $error("accepted block not sent");

  property p_no_take;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      !(i_ctl_tx_valid && o_ctl_tx_ready) |=> !o_link_tx_valid;
  endproperty
  a_no_take: assert property (p_no_take)
    else $error("block sent without handshake");

  property p_btf_zero;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (ctl_take && tx_no == 4'h0) |=> (o_link_tx_btf == 8'hd2);
  endproperty
  a_btf_zero: assert property (p_btf_zero)
    else $error("block 0 type field wrong");

  property p_btf_eight;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (ctl_take && tx_no == 4'h8) |=> (o_link_tx_btf == 8'h87);
  endproperty
  a_btf_eight: assert property (p_btf_eight)
    else $error("block 8 type field wrong");

  property p_payload;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      ctl_take |=> (o_link_tx_payload == ($past(i_little_endian)
        ? $past(i_ctl_tx_data[SLICE_W-1:LE_PL_LO])
        : $past(i_ctl_tx_data[DEF_PL_HI:0])));
  endproperty
  a_payload: assert property (p_payload)
    else $error("payload altered");

  property p_prio;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_ctl_tx_valid |-> !o_user_data_ready;
  endproperty
  a_prio: assert property (p_prio)
    else $error("user data ahead of control block");

  property p_rx_pulse;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_link_rx_valid && rx_hit) |=> o_ctl_rx_valid;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("received block not presented");

  property p_rx_zero;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_ctl_rx_valid && !$past(i_little_endian) |->
        o_ctl_rx_data[DEF_ZERO_HI:DEF_NO_HI+1] == 4'h0;
  endproperty
  a_rx_zero: assert property (p_rx_zero)
    else $error("default zero nibble not zero");

  property p_rx_le_zero;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_ctl_rx_valid && $past(i_little_endian) |->
        o_ctl_rx_data[LE_ZERO_HI:LE_ZERO_LO] == 4'h0;
  endproperty
  a_rx_le_zero: assert property (p_rx_le_zero)
    else $error("le zero nibble not zero");

  property p_rx_once;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      !$past(i_link_rx_valid) |-> !o_ctl_rx_valid;
  endproperty
  a_rx_once: assert property (p_rx_once)
    else $error("receive valid without new block");

  property p_ready_free;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      !(i_clock_compensation_req || i_channel_bonding_req
        || i_native_flow_control_req || i_user_flow_control_req)
        |-> o_ctl_tx_ready;
  endproperty
  a_ready_free: assert property (p_ready_free)
    else $error("ctl ready low with link free");

  property p_ud_free;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_user_data_valid && !i_ctl_tx_valid && o_ctl_tx_ready)
        |-> o_user_data_ready;
  endproperty
  a_ud_free: assert property (p_ud_free)
    else $error("user data held with link free");

  property p_ud_ufc;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_user_flow_control_req |-> !o_user_data_ready;
  endproperty
  a_ud_ufc: assert property (p_ud_ufc)
    else $error("user data ahead of flow control");

  property p_is_ctl;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_link_tx_is_ctl == o_link_tx_valid;
  endproperty
  a_is_ctl: assert property (p_is_ctl)
    else $error("control marker differs from valid");

  property p_idle_quiet;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      !o_link_tx_valid |->
        (o_link_tx_btf == 8'h00 && o_link_tx_payload == '0);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("link fields busy while idle");

  property p_bad_no;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (ctl_take && tx_no > 4'h8) |=>
        (o_ctl_tx_bad_no && o_link_tx_btf == 8'h00);
  endproperty
  a_bad_no: assert property (p_bad_no)
    else $error("undefined number not flagged");

  property p_good_no;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (ctl_take && tx_no <= 4'h8) |=> !o_ctl_tx_bad_no;
  endproperty
  a_good_no: assert property (p_good_no)
    else $error("defined number flagged");

  property p_rx_ignore;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_link_rx_valid && !rx_hit) |=> !o_ctl_rx_valid;
  endproperty
  a_rx_ignore: assert property (p_rx_ignore)
    else $error("unknown type field presented");

  property p_rx_hold;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      !o_ctl_rx_valid |-> $stable(o_ctl_rx_data);
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("receive data moved without valid");

  property p_rx_eight;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_link_rx_valid && i_link_rx_btf == 8'h87) |=>
        (($past(i_little_endian) ? o_ctl_rx_data[LE_NO_HI:0]
          : o_ctl_rx_data[DEF_NO_HI:DEF_NO_LO]) == 4'h8);
  endproperty
  a_rx_eight: assert property (p_rx_eight)
    else $error("type field 8 not mapped back");
endmodule : ackp_port

// >>> ackp_app_model.sv
// Purpose: Application-side model offering control blocks to the port.
// Assumes: Bus changes at falling edges only; a block is held until taken.
// Notes:   A released bus shows inverted data so stale values never match.
`timescale 1ns/1ps
module ackp_app_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_ready,
  input  wire logic        i_req,
  input  wire logic [63:0] i_word,
  output logic             o_valid,
  output logic [63:0]      o_data
);
  logic took;

  // The block counts as handed over only at an edge where ready was high
  always @(posedge i_ref_clk) begin
    took <= o_valid && i_ready;
  end

  always @(negedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_valid <= 1'b0;
      o_data  <= 64'h0;
    end else if (!o_valid || took) begin
      if (i_req) begin
        o_valid <= 1'b1;
        o_data  <= i_word;
      end else begin
        o_valid <= 1'b0;
        o_data  <= ~o_data;
      end
    end
  end
endmodule : ackp_app_model

// >>> ackp_port_tb.sv
// Purpose: Self-checking bench for the control block port.
// Assumes: Inputs change at falling edges; outputs are read there too.
// Notes:   Expected link blocks are queued at each accepted handshake.
`timescale 1ns/1ps
module ackp_port_tb;
  logic        clk, rst_b, le, framed, cc, cb, native_flow_control, ufc, udv;
  logic        app_req, app_valid, rx_v;
  logic [63:0] app_word, app_data, ctl_rx_data;
  logic [7:0]  rx_btf, link_btf;
  logic [55:0] rx_pl, link_pl;
  logic        tx_ready, ud_ready, link_v, link_ctl, bad_no, ctl_rx_v;
  logic [63:0] w;
  logic [3:0]  n;
  logic [64:0] expq [$];
  logic [7:0]  codes [9] = '{8'hd2, 8'h99, 8'h55, 8'hb4, 8'hcc, 8'h66,
                             8'h33, 8'h4b, 8'h87};
  int          err_count = 0;
  int          n_checks = 0;
  int          n_take = 0;
  int          k;

  always #25 clk = ~clk;

  ackp_app_model i_app (.i_ref_clk(clk), .i_rst_b(rst_b), .i_ready(tx_ready),
    .i_req(app_req), .i_word(app_word), .o_valid(app_valid),
    .o_data(app_data));

  ackp_port i_dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_little_endian(le),
    .i_framed_mode(framed), .i_clock_compensation_req(cc),
    .i_channel_bonding_req(cb), .i_native_flow_control_req(native_flow_control),
    .i_user_flow_control_req(ufc), .i_user_data_valid(udv),
    .i_ctl_tx_data(app_data), .i_ctl_tx_valid(app_valid),
    .o_ctl_tx_ready(tx_ready), .o_user_data_ready(ud_ready),
    .o_link_tx_valid(link_v), .o_link_tx_is_ctl(link_ctl),
    .o_link_tx_btf(link_btf), .o_link_tx_payload(link_pl),
    .o_ctl_tx_bad_no(bad_no), .i_link_rx_valid(rx_v),
    .i_link_rx_btf(rx_btf), .i_link_rx_payload(rx_pl),
    .o_ctl_rx_data(ctl_rx_data), .o_ctl_rx_valid(ctl_rx_v));

  task automatic chk(input string nm, input logic [64:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [55:0] pay(input int i);
    return {7{i[7:0] ^ 8'h3c}};
  endfunction : pay

  // Lane slice layouts for both orderings
  function automatic logic [63:0] mk(input logic l, input int i);
    return l ? {pay(i), 4'h0, i[3:0]}
             : {4'h0, i[3:0], pay(i)};
  endfunction : mk

  always @(posedge clk) begin
    if (rst_b && app_valid && tx_ready) begin
      w = app_data;
      n = le ? w[3:0] : w[59:56];
      expq.push_back({n > 4'h8, (n > 4'h8) ? 8'h00 : codes[n],
                      le ? w[63:8] : w[55:0]});
      n_take++;
    end
  end

  always @(negedge clk) begin
    if (link_v) begin
      if (expq.size() == 0) chk("tx extra", 1, 0);
      else chk("tx block", {bad_no, link_btf, link_pl},
               expq.pop_front());
      chk("tx is ctl", link_ctl, 1);
    end
  end

  // Numbers 0 to 9 back to back; 9 is out of range
  task automatic tx_all(input logic l, input logic f);
    int t0;
    t0 = n_take;
    @(negedge clk);
    le     <= l;
    framed <= f;
    for (int i = 0; i <= 9; i++) begin
      @(negedge clk);
      app_req  <= 1'b1;
      app_word <= mk(l, i);
    end
    @(negedge clk);
    app_req <= 1'b0;
    repeat (4) @(negedge clk);
    chk("tx pending", expq.size(), 0);
    chk("tx count", n_take - t0, 10);
  endtask : tx_all

  task automatic prio(input int j);
    int t0;
    t0 = n_take;
    @(negedge clk);
    {cc, cb, native_flow_control, ufc} <= 4'b1000 >> j;
    udv      <= 1'b1;
    app_req  <= 1'b1;
    app_word <= mk(le, 3);
    @(negedge clk);
    app_req <= 1'b0;
    repeat (3) begin
      @(negedge clk);
      chk("ready busy", {tx_ready, ud_ready}, 0);
    end
    chk("held", n_take, t0);
    {cc, cb, native_flow_control, ufc} <= 4'h0;
    @(negedge clk);
    chk("ready ctl", {tx_ready, ud_ready}, 2'b10);
    chk("taken", n_take, t0 + 1);
    @(negedge clk);
    chk("ready idle", {tx_ready, ud_ready}, 2'b11);
    udv <= 1'b0;
  endtask : prio

  // Nine codes back to back, then an unknown code, then silence
  task automatic rx_all(input logic l);
    logic [64:0] s, e;
    @(negedge clk);
    le <= l;
    for (int i = 0; i <= 11; i++) begin
      @(negedge clk);
      s = {ctl_rx_v, ctl_rx_data};
      e = {1'b1, mk(l, i - 1)};
      if (i > 0 && i < 10)
        chk("rx block", s, e);
      if (i >= 10)
        chk("rx hold", s, {1'b0, mk(l, 8)});
      rx_v   <= (i < 10);
      rx_btf <= (i < 9) ? codes[i] : 8'h1e;
      rx_pl  <= pay(i);
    end
  endtask : rx_all

  task automatic stop_test;
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  initial begin
    #200000;
    err_count++;
    stop_test;
  end

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    {le, framed, cc, cb, native_flow_control, ufc, udv, app_req, rx_v} = 9'h0;
    app_word = 64'h0;
    rx_btf = 8'h0;
    rx_pl = 56'h0;
    repeat (5) @(negedge clk);
    chk("reset", {link_v | ctl_rx_v, ctl_rx_data}, 0);
    rst_b <= 1'b1;
    tx_all(1'b0, 1'b0);
    tx_all(1'b1, 1'b1);
    for (k = 0; k < 4; k++) prio(k);
    rx_all(1'b0);
    rx_all(1'b1);
    stop_test;
  end
endmodule : ackp_port_tb
